// ==== core/synth_pkg.sv ====
// shared constants, types and helpers for the fractional-n synthesizer core
package synth_pkg;

	// bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// divider and fraction widths
	localparam int FRAC_W = 22;
	localparam int NINT_W = 16;
	localparam int NCUR_W = 17;
	localparam int RDIV_W = 16;
	localparam int OSCF_W = 8;
	localparam int DLY_W  = 3;
	localparam int CALC_W = 24;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CFG0   = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_RDIV   = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_NINT   = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_NUM    = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_DEN    = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_TUNE   = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h18;

	// first config register field positions
	localparam int CFG0_SKIP_BIT  = 0;
	localparam int CFG0_ORDER_LSB = 1;
	localparam int CFG0_DITH_LSB  = 3;
	localparam int CFG0_DBL_BIT   = 5;

	// tune register and status field positions
	localparam int TUNE_OSCF_LSB  = 0;
	localparam int TUNE_DLY_LSB   = 8;
	localparam int STAT_BUSY_BIT  = 0;
	localparam int STAT_DONE_BIT  = 1;
	localparam int STAT_NCUR_LSB  = 8;

	// reset values, unit constants and lfsr taps
	localparam logic [RDIV_W-1:0] RDIV_RST = 16'h0001;
	localparam logic [NINT_W-1:0] NINT_RST = 16'h0010;
	localparam logic [FRAC_W-1:0] DEN_RST  = 22'h000001;
	localparam logic [FRAC_W-1:0] DEN_ONE  = 22'h000001;
	localparam logic [NCUR_W-1:0] NCUR_ONE = 17'h00001;
	localparam logic [15:0]       LFSR_SEED = 16'hACE1;
	localparam logic [15:0]       LFSR_TAPS = 16'hB400;

	typedef enum logic [1:0] {
		ORDER_INT    = 2'h0,
		ORDER_FIRST  = 2'h1,
		ORDER_SECOND = 2'h2,
		ORDER_THIRD  = 2'h3
	} mod_order_type;

	typedef enum logic [1:0] {
		DITHER_OFF    = 2'h0,
		DITHER_WEAK   = 2'h1,
		DITHER_MEDIUM = 2'h2,
		DITHER_STRONG = 2'h3
	} dither_type;

	// gray coded: idle -> run -> done
	typedef enum logic [1:0] {
		CAL_IDLE = 2'b00,
		CAL_RUN  = 2'b01,
		CAL_DONE = 2'b11
	} cal_state_type;

	typedef struct packed {
		logic          dbl;
		dither_type    dither;
		mod_order_type order;
		logic          skip;
	} cfg_type;

	typedef struct packed {
		logic [ADDR_W-1:0] paddr;
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [DATA_W-1:0] pwdata;
	} apb_req_type;

	typedef struct packed {
		logic [DATA_W-1:0] prdata;
		logic              pready;
		logic              pslverr;
	} apb_rsp_type;

	// modular accumulator step: returns {carry, residue}
	function automatic logic [FRAC_W:0] acc_step(
		input logic [FRAC_W-1:0] acc,
		input logic [FRAC_W:0]   inc,
		input logic [FRAC_W-1:0] den
	);
		logic [FRAC_W+1:0] sum;
		logic              carry;
		sum   = {2'b00, acc} + {1'b0, inc};
		carry = 1'b0;
		if (sum >= {2'b00, den}) begin
			sum   = sum - {2'b00, den};
			carry = 1'b1;
		end
		// dither can push the sum past twice the modulus
		if (sum >= {2'b00, den}) begin
			sum = sum - {2'b00, den};
		end
		return {carry, sum[FRAC_W-1:0]};
	endfunction

endpackage

// ==== core/dither_source.sv ====
// pseudo-random dither source for the fractional modulator
module dither_source import synth_pkg::*; (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       restart,
	input  wire logic       step,
	input  wire dither_type mode,
	output logic [3:0]      dith
);

	typedef struct packed {
		logic [15:0] lfsr;
	} dith_state_type;

	dith_state_type r_reg;
	dith_state_type r_next;

	// galois lfsr; reseeded on restart so sequences repeat
	always_comb begin
		r_next = r_reg;
		if (restart) begin
			r_next.lfsr = LFSR_SEED;
		end else if (step) begin
			r_next.lfsr = r_reg.lfsr[0] ? ((r_reg.lfsr >> 1) ^ LFSR_TAPS)
				: (r_reg.lfsr >> 1);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			r_reg.lfsr <= LFSR_SEED;
		end else begin
			r_reg <= r_next;
		end
	end

	// dither amplitude by mode
	always_comb begin
		case (mode)
			DITHER_WEAK:   dith = {3'b000, r_reg.lfsr[0]};
			DITHER_MEDIUM: dith = {2'b00, r_reg.lfsr[1:0]};
			DITHER_STRONG: dith = r_reg.lfsr[3:0];
			default:       dith = 4'h0;
		endcase
	end

endmodule // dither_source

// ==== core/frac_n_core.sv ====
// reference path, fractional-n feedback divider and calibration launcher
module frac_n_core import synth_pkg::*; #(
	parameter int CAL_PER_UNIT = 4
) (
	input  wire logic              clk,
	input  wire logic              srst,
	input  wire apb_req_type       apb_req,
	output apb_rsp_type            apb_rsp,
	input  wire logic              reference_input,
	input  wire logic              vco_input,
	output logic                   pd_tick,
	output logic                   fb_tick,
	output logic [NCUR_W-1:0]      n_value,
	output logic [DLY_W-1:0]       detector_delay_setting,
	output logic                   cal_busy,
	output logic                   cal_done
);

	initial begin
		if (CAL_PER_UNIT < 1 || CAL_PER_UNIT > 65535) begin
			$error("CAL_PER_UNIT out of range");
		end
	end

	typedef struct packed {
		cfg_type           cfg;
		logic [RDIV_W-1:0] rdiv;
		logic [NINT_W-1:0] nint;
		logic [FRAC_W-1:0] num;
		logic [FRAC_W-1:0] den;
		logic [OSCF_W-1:0] oscf;
		logic [DLY_W-1:0]  dly;
		logic              ref_prev;
		logic              vco_prev;
		logic [RDIV_W-1:0] rcount;
		logic [FRAC_W-1:0] acc1;
		logic [FRAC_W-1:0] acc2;
		logic [FRAC_W-1:0] acc3;
		logic              c2d;
		logic              c3d;
		logic              c3dd;
		logic [NCUR_W-1:0] n_cur;
		logic [NCUR_W-1:0] fcount;
		logic              pd_out;
		logic              fb_out;
		cal_state_type     cal;
		logic [CALC_W-1:0] cal_count;
		logic [DATA_W-1:0] prdata;
	} core_state_type;

	core_state_type r_reg;
	core_state_type r_next;

	logic              setup;     // apb setup phase
	logic              access;    // apb access phase
	logic              wr;        // write taking effect now
	logic              wr_cfg0;   // write to first config register
	logic [DATA_W:0]   rd_hit;    // {mapped, read data}
	logic [3:0]        dith;      // dither amplitude
	logic              ref_rise;  // reference rising edge
	logic              ref_evt;   // reference event after doubler
	logic              vco_rise;  // feedback input edge
	logic              fb_evt;    // feedback divider wraps
	logic [FRAC_W:0]   s1;
	logic [FRAC_W:0]   s2;
	logic [FRAC_W:0]   s3;
	logic signed [3:0] delta;     // modulator correction
	logic signed [NCUR_W:0] nsum;
	logic [CALC_W-1:0] cal_target;

	// register read decode, also used for the unmapped answer
	function automatic logic [DATA_W:0] read_mux(
		input logic [ADDR_W-1:0] a,
		input core_state_type    s
	);
		logic [DATA_W-1:0] d;
		d = '0;
		if (a == OFF_CFG0) begin
			d[CFG0_DBL_BIT:0] = s.cfg;
		end else if (a == OFF_RDIV) begin
			d[RDIV_W-1:0] = s.rdiv;
		end else if (a == OFF_NINT) begin
			d[NINT_W-1:0] = s.nint;
		end else if (a == OFF_NUM) begin
			d[FRAC_W-1:0] = s.num;
		end else if (a == OFF_DEN) begin
			d[FRAC_W-1:0] = s.den;
		end else if (a == OFF_TUNE) begin
			d[TUNE_OSCF_LSB +: OSCF_W] = s.oscf;
			d[TUNE_DLY_LSB +: DLY_W]   = s.dly;
		end else if (a == OFF_STATUS) begin
			d[STAT_BUSY_BIT]          = (s.cal == CAL_RUN);
			d[STAT_DONE_BIT]          = (s.cal == CAL_DONE);
			d[STAT_NCUR_LSB +: NCUR_W] = s.n_cur;
		end else begin
			return {1'b0, d};
		end
		return {1'b1, d};
	endfunction

	// bus phases; zero wait states
	assign setup    = apb_req.psel & ~apb_req.penable;
	assign access   = apb_req.psel & apb_req.penable;
	assign wr       = access & apb_req.pwrite;
	assign wr_cfg0  = wr & (apb_req.paddr == OFF_CFG0);
	assign rd_hit   = read_mux(apb_req.paddr, r_reg);
	// one driver for the whole response struct
	assign apb_rsp = '{prdata:  r_reg.prdata,
		pready:  access,
		pslverr: access & ~rd_hit[DATA_W]};

	// edges of the pins; pins are synchronous to clk
	assign ref_rise = reference_input & ~r_reg.ref_prev;
	assign ref_evt  = r_reg.cfg.dbl ? (reference_input ^ r_reg.ref_prev)
		: ref_rise;
	assign vco_rise = vco_input & ~r_reg.vco_prev;
	assign fb_evt   = vco_rise & (r_reg.fcount >= r_reg.n_cur - NCUR_ONE);

	dither_source u_dither (
		.clk     (clk),
		.srst    (srst),
		.restart (wr_cfg0),
		.step    (fb_evt),
		.mode    (r_reg.cfg.dither),
		.dith    (dith)
	);

	// mash accumulator chain, one step per feedback period
	always_comb begin
		s1 = acc_step(r_reg.acc1, {1'b0, r_reg.num} + {19'h0, dith},
			r_reg.den);
		s2 = acc_step(r_reg.acc2, {1'b0, s1[FRAC_W-1:0]}, r_reg.den);
		s3 = acc_step(r_reg.acc3, {1'b0, s2[FRAC_W-1:0]}, r_reg.den);
		case (r_reg.cfg.order)
			ORDER_FIRST:  delta = $signed({3'b000, s1[FRAC_W]});
			ORDER_SECOND: delta = $signed({3'b000, s1[FRAC_W]})
				+ $signed({3'b000, s2[FRAC_W]})
				- $signed({3'b000, r_reg.c2d});
			ORDER_THIRD:  delta = $signed({3'b000, s1[FRAC_W]})
				+ $signed({3'b000, s2[FRAC_W]})
				- $signed({3'b000, r_reg.c2d})
				+ $signed({3'b000, s3[FRAC_W]})
				- $signed({2'b00, r_reg.c3d, 1'b0})
				+ $signed({3'b000, r_reg.c3dd});
			default:      delta = 4'sh0;
		endcase
		// ratio is integer part plus mean of carries, num/den
		nsum = $signed({2'b00, r_reg.nint})
			+ {{(NCUR_W-3){delta[3]}}, delta};
	end

	// calibration length in reference cycles
	assign cal_target = CALC_W'(r_reg.oscf) * CALC_W'(CAL_PER_UNIT);

	// next-state logic for the whole block
	always_comb begin
		r_next          = r_reg;
		r_next.pd_out   = 1'b0;
		r_next.fb_out   = 1'b0;
		r_next.ref_prev = reference_input;
		r_next.vco_prev = vco_input;

		// read data captured in setup, shown in access
		if (setup) begin
			r_next.prdata = rd_hit[DATA_W-1:0];
		end

		// reference path: count events, tick every rdiv of them
		if (ref_evt) begin
			if (r_reg.rcount >= r_reg.rdiv - RDIV_RST) begin
				r_next.rcount = '0;
				r_next.pd_out = 1'b1;
			end else begin
				r_next.rcount = r_reg.rcount + RDIV_RST;
			end
		end

		// feedback divider with modulator update at each wrap
		if (vco_rise) begin
			if (fb_evt) begin
				r_next.fcount = '0;
				r_next.fb_out = 1'b1;
				r_next.acc1   = s1[FRAC_W-1:0];
				r_next.acc2   = s2[FRAC_W-1:0];
				r_next.acc3   = s3[FRAC_W-1:0];
				r_next.c2d    = s2[FRAC_W];
				r_next.c3d    = s3[FRAC_W];
				r_next.c3dd   = r_reg.c3d;
				// a ratio below one cannot be divided
				r_next.n_cur  = (nsum < 1) ? NCUR_ONE : nsum[NCUR_W-1:0];
			end else begin
				r_next.fcount = r_reg.fcount + NCUR_ONE;
			end
		end

		// calibration runs on reference edges
		if (r_reg.cal == CAL_RUN && ref_rise) begin
			if (r_reg.cal_count + 1'b1 >= cal_target) begin
				r_next.cal = CAL_DONE;
			end else begin
				r_next.cal_count = r_reg.cal_count + 1'b1;
			end
		end

		// register writes
		if (wr) begin
			if (apb_req.paddr == OFF_CFG0) begin
				r_next.cfg = apb_req.pwdata[CFG0_DBL_BIT:0];
			end else if (apb_req.paddr == OFF_RDIV) begin
				// zero would never wrap; held as one
				r_next.rdiv = (apb_req.pwdata[RDIV_W-1:0] == '0) ? RDIV_RST
					: apb_req.pwdata[RDIV_W-1:0];
			end else if (apb_req.paddr == OFF_NINT) begin
				r_next.nint = apb_req.pwdata[NINT_W-1:0];
			end else if (apb_req.paddr == OFF_NUM) begin
				r_next.num = apb_req.pwdata[FRAC_W-1:0];
			end else if (apb_req.paddr == OFF_DEN) begin
				r_next.den = (apb_req.pwdata[FRAC_W-1:0] == '0) ? DEN_ONE
					: apb_req.pwdata[FRAC_W-1:0];
			end else if (apb_req.paddr == OFF_TUNE) begin
				r_next.oscf = apb_req.pwdata[TUNE_OSCF_LSB +: OSCF_W];
				r_next.dly  = apb_req.pwdata[TUNE_DLY_LSB +: DLY_W];
			end
		end

		// first config write restarts modulator and divider
		if (wr_cfg0) begin
			r_next.acc1   = '0;
			r_next.acc2   = '0;
			r_next.acc3   = '0;
			r_next.c2d    = 1'b0;
			r_next.c3d    = 1'b0;
			r_next.c3dd   = 1'b0;
			r_next.fcount = '0;
			r_next.fb_out = 1'b0;
			r_next.n_cur  = (r_reg.nint == '0) ? NCUR_ONE
				: {1'b0, r_reg.nint};
			if (!apb_req.pwdata[CFG0_SKIP_BIT]) begin
				r_next.cal       = CAL_RUN;
				r_next.cal_count = '0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			r_reg        <= '0;
			r_reg.rdiv   <= RDIV_RST;
			r_reg.nint   <= NINT_RST;
			r_reg.den    <= DEN_RST;
			r_reg.n_cur  <= {1'b0, NINT_RST};
			r_reg.cal    <= CAL_IDLE;
		end else begin
			r_reg <= r_next;
		end
	end

	// outputs straight from state
	assign pd_tick                = r_reg.pd_out;
	assign fb_tick                = r_reg.fb_out;
	assign n_value                = r_reg.n_cur;
	assign detector_delay_setting = r_reg.dly;
	assign cal_busy               = (r_reg.cal == CAL_RUN);
	assign cal_done               = (r_reg.cal == CAL_DONE);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	// a doubled reference at half clk rate with rdiv of one ticks every cycle
	a_pd_spacing: assert property (
		pd_tick && r_reg.rdiv > RDIV_RST |=> !pd_tick
	) else $error("phase detector ticks back to back");

	a_den_nonzero: assert property (
		r_reg.den != '0
	) else $error("denominator is zero");

	a_first_order: assert property (
		fb_tick && $past(r_reg.cfg.order) == ORDER_FIRST && !$past(wr)
		|-> (n_value == {1'b0, $past(r_reg.nint)}
			|| n_value == {1'b0, $past(r_reg.nint)} + NCUR_ONE)
	) else $error("first order ratio out of range");

	a_int_mode: assert property (
		fb_tick && $past(r_reg.cfg.order) == ORDER_INT
		&& $past(r_reg.nint) != '0
		|-> n_value == {1'b0, $past(r_reg.nint)}
	) else $error("integer mode ratio differs from integer part");

	a_cfg0_restart: assert property (
		wr_cfg0 |=> r_reg.acc1 == '0 && r_reg.acc3 == '0
			&& r_reg.fcount == '0 && !fb_tick
	) else $error("modulator not restarted by config write");

	a_dither_off: assert property (
		r_reg.cfg.dither == DITHER_OFF |-> dith == 4'h0
	) else $error("dither present while disabled");

	a_cal_start: assert property (
		wr_cfg0 && !apb_req.pwdata[CFG0_SKIP_BIT]
		|=> cal_busy && r_reg.cal_count == '0
	) else $error("calibration not started");

	a_cal_skip: assert property (
		wr_cfg0 && apb_req.pwdata[CFG0_SKIP_BIT] && !cal_busy
		|=> !cal_busy
	) else $error("calibration started with skip set");

	c_cal_done: cover property (cal_busy ##1 cal_done);
	c_third_order: cover property (
		fb_tick && r_reg.cfg.order == ORDER_THIRD);
	c_doubled_tick: cover property (pd_tick && r_reg.cfg.dbl);

endmodule // frac_n_core

// ==== test/ref_osc_model.sv ====
// reference oscillator and divided-oscillator source for the core
module ref_osc_model #(
	parameter int HALF = 2 // reference half period in clk cycles
) (
	input  wire logic clk,
	output logic      reference_input,
	output logic      vco_input
);
	timeunit 1ns;
	timeprecision 1ns;

	int cnt; // cycles spent in the current reference half period

	initial begin
		reference_input = 1'b0;
		vco_input       = 1'b0;
		cnt             = 0;
	end

	// both sources run free, so config writes never meet a dead reference
	always @(posedge clk) begin
		vco_input <= ~vco_input;
		cnt       <= (cnt + 1 >= HALF) ? 0 : cnt + 1;
		if (cnt + 1 >= HALF) begin
			reference_input <= ~reference_input;
		end
	end
endmodule // ref_osc_model

// ==== test/frac_n_core_tb.sv ====
// self-checking bench for the fractional-n core
module frac_n_core_tb import synth_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;

	logic              clk;
	logic              srst;
	apb_req_type       apb_req;
	apb_rsp_type       apb_rsp;
	logic              reference_input, vco_input, pd_tick, fb_tick;
	logic              cal_busy, cal_done, e, rp;
	logic [NCUR_W-1:0] n_value;
	logic [DLY_W-1:0]  detector_delay_setting;
	logic [31:0]       q, den, num, nint, sig0, sig1, sig2;
	int                fails, samples_checked, seed, i, o, dv, cnt, ex;
	int                rises;

	frac_n_core #(.CAL_PER_UNIT(1)) dut (.clk(clk), .srst(srst),
		.apb_req(apb_req), .apb_rsp(apb_rsp),
		.reference_input(reference_input), .vco_input(vco_input),
		.pd_tick(pd_tick), .fb_tick(fb_tick), .n_value(n_value),
		.detector_delay_setting(detector_delay_setting),
		.cal_busy(cal_busy), .cal_done(cal_done));
	ref_osc_model #(.HALF(2)) osc (.clk(clk),
		.reference_input(reference_input), .vco_input(vco_input));

	initial clk = 1'b0;
	always #50 clk = ~clk;

	task automatic chk(input string what, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one apb transfer; an idle cycle follows so strobes never re-assert
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		apb_req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: d};
		@(posedge clk);
		apb_req.penable <= 1'b1;
		do @(posedge clk); while (apb_rsp.pready !== 1'b1);
		q = apb_rsp.prdata;
		e = apb_rsp.pslverr;
		apb_req.psel    <= 1'b0;
		apb_req.penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	// vco rises over n wraps, and a signature of the ratio sequence
	task automatic measure(input int n, output int r, output logic [31:0] s);
		logic vp;
		int   w;
		r  = 0;
		s  = '0;
		w  = -1;
		vp = vco_input;
		while (w < n) begin
			@(posedge clk);
			if (w >= 0 && vco_input && !vp) r++;
			vp = vco_input;
			if (fb_tick === 1'b1) begin
				w++;
				s = {s[30:0], s[31]} ^ 32'(n_value);
			end
		end
	endtask

	task automatic conclude;
		if (fails == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// watchdog sized well past the longest expected run
	initial begin
		repeat (100000) @(posedge clk);
		fails++;
		conclude();
	end

	initial begin
		seed            = 86999;
		fails           = 0;
		samples_checked = 0;
		srst            = 1'b1;
		apb_req         = '0;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		// reset values, then the unmapped and read-only places
		bus(1'b0, OFF_RDIV, '0);
		chk("rdiv reset", q, 32'h00000001);
		bus(1'b0, OFF_NINT, '0);
		chk("nint reset", q, 32'h00000010);
		bus(1'b0, OFF_DEN, '0);
		chk("den reset", q, 32'h00000001);
		bus(1'b0, OFF_STATUS, '0);
		chk("status reset", q, 32'h00001000);
		bus(1'b0, 8'h1C, '0);
		chk("unmapped err", {31'h0, e}, 32'h00000001);
		chk("unmapped data", q, 32'h00000000);
		wr(OFF_STATUS, 32'hFFFFFFFF);
		chk("status write err", {31'h0, e}, 32'h00000000);
		// denominator limits
		wr(OFF_DEN, 32'hFFFFFFFF);
		bus(1'b0, OFF_DEN, '0);
		chk("den max", q, 32'h003FFFFF);
		wr(OFF_DEN, 32'h00000000);
		bus(1'b0, OFF_DEN, '0);
		chk("den zero", q, 32'h00000001);
		wr(OFF_TUNE, 32'h00000503);
		chk("delay", 32'(detector_delay_setting), 32'h00000005);
		bus(1'b0, OFF_TUNE, '0);
		chk("tune read", q, 32'h00000503);
		wr(OFF_RDIV, 32'h00000000);
		bus(1'b0, OFF_RDIV, '0);
		chk("rdiv zero", q, 32'h00000001);
		// doubler and r divider together, 24 reference periods
		for (i = 0; i < 4; i++) begin
			wr(OFF_RDIV, (i < 2) ? 32'h00000001 : 32'h00000003);
			wr(OFF_CFG0, 32'((i % 2) << CFG0_DBL_BIT) | 32'h00000001);
			ex  = 24 * (1 + i % 2) / ((i < 2) ? 1 : 3);
			cnt = 0;
			repeat (96) begin
				@(posedge clk);
				if (pd_tick === 1'b1) cnt++;
			end
			chk("pd ticks", 32'(cnt >= ex - 1 && cnt <= ex + 1), 32'h1);
		end
		// calibration: write right after a reference rise
		rp = 1'b1;
		while (!(reference_input === 1'b1 && rp === 1'b0)) begin
			rp = reference_input;
			@(posedge clk);
		end
		wr(OFF_CFG0, 32'h00000000);
		chk("cal busy", {31'h0, cal_busy}, 32'h1);
		cnt = 0;
		i   = 0;
		rp  = reference_input;
		while (cal_done !== 1'b1 && i < 200) begin
			@(posedge clk);
			i++;
			if (reference_input && !rp) cnt++;
			rp = reference_input;
		end
		chk("cal edges", 32'(cnt), 32'h00000003);
		chk("cal idle", {31'h0, cal_busy}, 32'h0);
		wr(OFF_CFG0, 32'h00000001);
		chk("skip cal", {31'h0, cal_busy}, 32'h0);
		// integer mode, zero numerator, dither off
		wr(OFF_NINT, 32'h00000004);
		wr(OFF_NUM, 32'h00000000);
		wr(OFF_CFG0, 32'h00000001);
		measure(64, rises, sig0);
		chk("integer ratio", 32'(rises), 32'd256);
		// first order with a small denominator, exact over 64 wraps
		wr(OFF_NUM, 32'h00000001);
		wr(OFF_DEN, 32'h00000004);
		wr(OFF_CFG0, 32'h00000003);
		measure(64, rises, sig0);
		chk("first order ratio", 32'(rises), 32'd272);
		// random fractions for the first, second and third orders and every dither mode
		for (o = 1; o < 4; o++) begin
			// power-of-two denominators stay above 200 once reduced
			den  = 32'(512 << ({$random(seed)} % 3));
			// odd top numerator: any first-step dither adds a carry
			num  = den - 32'h00000001;
			nint = 32'(4 + {$random(seed)} % 4);
			wr(OFF_NINT, nint);
			wr(OFF_NUM, num);
			wr(OFF_DEN, den);
			ex = 64 * int'(nint) + 64 * int'(num) / int'(den);
			for (dv = 0; dv < 4; dv++) begin
				wr(OFF_CFG0, 32'((dv << 3) | (o << 1) | 1));
				measure(64, rises, sig1);
				chk("frac ratio", 32'(rises >= ex - 4 && rises <= ex + 4), 32'h1);
				wr(OFF_CFG0, 32'((dv << 3) | (o << 1) | 1));
				measure(64, rises, sig2);
				chk("restart repeat", sig2, sig1);
				if (dv == 0) sig0 = sig1;
				else chk("dither differs", 32'(sig1 != sig0), 32'h1);
			end
		end
		conclude();
	end
endmodule // frac_n_core_tb
